// >>> hw/ssdm_pkg.sv
// Constants, register map and carriers of the serial port status/data block
`default_nettype none
package ssdm_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_DATA    = 8'h08;
	// Status bit positions
	localparam int STAT_DONE = 7;
	localparam int STAT_COL  = 6;
	localparam int STAT_DBL  = 0;
	// Index of the last serial clock edge of a transfer
	localparam logic [3:0] LAST_EDGE = 4'hF;
	// Half serial periods in system clocks, normal then double rate
	localparam logic [6:0] HALF_N0 = 7'h02;
	localparam logic [6:0] HALF_N1 = 7'h08;
	localparam logic [6:0] HALF_N2 = 7'h20;
	localparam logic [6:0] HALF_N3 = 7'h40;
	localparam logic [6:0] HALF_D0 = 7'h01;
	localparam logic [6:0] HALF_D1 = 7'h04;
	localparam logic [6:0] HALF_D2 = 7'h10;
	localparam logic [6:0] HALF_D3 = 7'h20;
	localparam logic [6:0] HALF_ONE = 7'h01;

	// Control register fields, highest bit first in the word
	typedef struct packed {
		logic ssPinInput;        // Bit 8
		logic transferIrqEnable; // Bit 7
		logic portEnable;        // Bit 6
		logic lsbFirst;          // Bit 5
		logic masterMode;        // Bit 4
		logic clockPolarityBit;  // Bit 3
		logic clockPhaseBit;     // Bit 2
		logic rateSelectHigh;    // Bit 1
		logic rateSelectLow;     // Bit 0
	} ssdm_control_s;

	// Serial pins as sampled, in synchroniser order
	typedef struct packed {
		logic selectN;
		logic sck;
		logic mosi;
		logic miso;
	} ssdm_pins_s;

	// Half period of the master clock in system clocks
	function automatic logic [6:0] halfPeriod(input logic [1:0] rate, input logic dbl);
		logic [6:0] h;
		h = HALF_N0;
		unique case ({dbl, rate})
			3'h0: h = HALF_N0;
			3'h1: h = HALF_N1;
			3'h2: h = HALF_N2;
			3'h3: h = HALF_N3;
			3'h4: h = HALF_D0;
			3'h5: h = HALF_D1;
			3'h6: h = HALF_D2;
			3'h7: h = HALF_D3;
		endcase
		return h;
	endfunction
endpackage
`default_nettype wire

// >>> hw/ssdm_serial_port.sv
// Serial port with status, data register, clock modes and APB access
`default_nettype none
module ssdm_serial_port (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// Processor interrupt side
	input  wire logic        globalIrqEnable,
	input  wire logic        vectorTaken,
	output var  logic        irq,
	// Serial pins
	input  wire logic        selectInN,
	input  wire logic        sckIn,
	input  wire logic        mosiIn,
	input  wire logic        misoIn,
	output var  logic        sckOut,
	output var  logic        sckOe,
	output var  logic        mosiOut,
	output var  logic        mosiOe,
	output var  logic        misoOut,
	output var  logic        misoOe
);
	typedef struct packed {
		ssdm_pkg::ssdm_control_s ctrl;
		logic                    doubleRateBit;
		logic                    transferDoneFlag;
		logic                    writeCollisionFlag;
		logic                    armDone;
		logic                    armCol;
		logic [7:0]              rxBuffer;
		logic [7:0]              txShift;
		logic [7:0]              rxShift;
		logic [3:0]              edgeCnt;
		logic [6:0]              divCnt;
		logic                    running;
		logic                    sckLevel;
		logic                    dataOut;
		ssdm_pkg::ssdm_pins_s    sync1;
		ssdm_pkg::ssdm_pins_s    sync2;
		ssdm_pkg::ssdm_pins_s    sync3;
		ssdm_pkg::ssdm_pins_s    pinF;
		logic                    prevSck;
		logic                    ready;
		logic                    slvErr;
		logic [31:0]             rdata;
		logic                    irqLine;
		logic                    masterDrive;
		logic                    slaveDrive;
	} ssdm_state_s;

	ssdm_state_s q;
	ssdm_state_s next_q;

	// Current outgoing bit of the transmit shifter
	function automatic logic outBit(input logic [7:0] s, input logic lsb);
		return lsb ? s[0] : s[7];
	endfunction

	// Transmit shifter after one bit went out
	function automatic logic [7:0] shiftOut(input logic [7:0] s, input logic lsb);
		return lsb ? {1'b0, s[7:1]} : {s[6:0], 1'b0};
	endfunction

	// Receive shifter after one bit came in
	function automatic logic [7:0] shiftIn(input logic [7:0] s, input logic lsb, input logic b);
		return lsb ? {b, s[7:1]} : {s[6:0], b};
	endfunction

	// Status word; reserved bits stay zero
	function automatic logic [31:0] statusWord(input logic d, input logic c, input logic x);
		logic [31:0] w;
		w = '0;
		w[ssdm_pkg::STAT_DONE] = d;
		w[ssdm_pkg::STAT_COL] = c;
		w[ssdm_pkg::STAT_DBL] = x;
		return w;
	endfunction

	logic       setupPhase;
	logic       accessDone;
	logic       addrCtrl;
	logic       addrStat;
	logic       addrData;
	logic       busy;
	logic       clockEdge;
	logic       sampleNow;
	logic       emitNow;
	logic       finish;
	logic       slaveSelected;
	logic       serialIn;
	logic       setDone;
	logic       setCol;
	logic       clearDone;
	logic       clearCol;
	logic [6:0] half;

	// Bus decode and transfer status
	always_comb begin
		setupPhase = psel && !penable;
		accessDone = psel && penable && q.ready;
		addrCtrl = (paddr == ssdm_pkg::ADDR_CONTROL);
		addrStat = (paddr == ssdm_pkg::ADDR_STATUS);
		addrData = (paddr == ssdm_pkg::ADDR_DATA);
		busy = q.running || (q.edgeCnt != '0);
		slaveSelected = q.ctrl.portEnable && !q.ctrl.masterMode && !q.pinF.selectN;
		half = ssdm_pkg::halfPeriod({q.ctrl.rateSelectHigh, q.ctrl.rateSelectLow},
			q.doubleRateBit);
		serialIn = q.ctrl.masterMode ? q.pinF.miso : q.pinF.mosi;
	end

	// Serial clock edge detection for both roles
	always_comb begin
		if (q.ctrl.masterMode) begin
			clockEdge = q.running && (q.divCnt == half - ssdm_pkg::HALF_ONE);
		end else begin
			clockEdge = slaveSelected && (q.pinF.sck != q.prevSck);
		end
		// Even edge index is leading; phase picks the sampling edge
		sampleNow = clockEdge && (q.edgeCnt[0] == q.ctrl.clockPhaseBit);
		emitNow = clockEdge && !sampleNow && (q.edgeCnt != '0);
		finish = clockEdge && (q.edgeCnt == ssdm_pkg::LAST_EDGE);
	end

	// Next state
	always_comb begin
		next_q = q;
		setDone = 1'b0;
		setCol = 1'b0;
		clearDone = 1'b0;
		clearCol = 1'b0;

		// Three-stage pin synchronisers, change taken when stages agree
		next_q.sync1 = '{selectN: selectInN, sck: sckIn, mosi: mosiIn, miso: misoIn};
		next_q.sync2 = q.sync1;
		next_q.sync3 = q.sync2;
		if (q.sync2.selectN == q.sync3.selectN) begin
			next_q.pinF.selectN = q.sync3.selectN;
		end
		if (q.sync2.sck == q.sync3.sck) begin
			next_q.pinF.sck = q.sync3.sck;
		end
		if (q.sync2.mosi == q.sync3.mosi) begin
			next_q.pinF.mosi = q.sync3.mosi;
		end
		if (q.sync2.miso == q.sync3.miso) begin
			next_q.pinF.miso = q.sync3.miso;
		end
		next_q.prevSck = q.pinF.sck;

		// Bus answer: one access cycle, read data caught at setup
		next_q.ready = setupPhase;
		next_q.slvErr = setupPhase && !(addrCtrl || addrStat || addrData);
		if (setupPhase) begin
			if (addrCtrl) begin
				next_q.rdata = 32'(q.ctrl);
			end else if (addrStat) begin
				next_q.rdata = statusWord(q.transferDoneFlag, q.writeCollisionFlag,
					q.doubleRateBit);
			end else if (addrData) begin
				next_q.rdata = 32'(q.rxBuffer);
			end else begin
				next_q.rdata = '0;
			end
		end

		// Register writes and read side effects at the completing edge
		if (accessDone && pwrite && addrCtrl) begin
			next_q.ctrl = ssdm_pkg::ssdm_control_s'(pwdata[$bits(ssdm_pkg::ssdm_control_s)-1:0]);
		end
		if (accessDone && pwrite && addrStat) begin
			next_q.doubleRateBit = pwdata[ssdm_pkg::STAT_DBL];
		end
		if (accessDone && !pwrite && addrStat) begin
			next_q.armDone = q.rdata[ssdm_pkg::STAT_DONE];
			next_q.armCol = q.rdata[ssdm_pkg::STAT_COL];
		end
		if (accessDone && addrData) begin
			clearDone = q.armDone || q.armCol;
			clearCol = q.armCol;
			next_q.armDone = 1'b0;
			next_q.armCol = 1'b0;
		end
		if (vectorTaken) begin
			clearDone = 1'b1;
		end

		// Data write: load and start, or flag a collision and leave the shifter
		if (accessDone && pwrite && addrData) begin
			if (busy) begin
				setCol = 1'b1;
			end else begin
				next_q.txShift = pwdata[7:0];
				next_q.edgeCnt = '0;
				next_q.divCnt = '0;
				next_q.running = q.ctrl.masterMode && q.ctrl.portEnable;
				next_q.sckLevel = q.ctrl.clockPolarityBit;
			end
		end

		// Master divider
		if (q.running) begin
			next_q.divCnt = clockEdge ? '0 : q.divCnt + ssdm_pkg::HALF_ONE;
		end

		// Bit engine shared by master and slave
		if (clockEdge) begin
			next_q.edgeCnt = q.edgeCnt + 4'h1;
			if (q.ctrl.masterMode) begin
				next_q.sckLevel = !q.sckLevel;
			end
		end
		if (sampleNow) begin
			next_q.rxShift = shiftIn(q.rxShift, q.ctrl.lsbFirst, serialIn);
		end
		if (emitNow) begin
			next_q.txShift = shiftOut(q.txShift, q.ctrl.lsbFirst);
		end
		if (finish) begin
			next_q.running = 1'b0;
			next_q.edgeCnt = '0;
			next_q.rxBuffer = sampleNow ? shiftIn(q.rxShift, q.ctrl.lsbFirst, serialIn)
				: q.rxShift;
			setDone = 1'b1;
		end

		// Idle clock level follows polarity when no transfer runs
		if (!q.running) begin
			next_q.sckLevel = q.ctrl.clockPolarityBit;
		end

		// Deselected slave drops its partial byte
		if (!q.ctrl.masterMode && q.pinF.selectN) begin
			next_q.edgeCnt = '0;
		end

		// Select pulled low while master with select as input
		if (q.ctrl.portEnable && q.ctrl.masterMode && q.ctrl.ssPinInput && !q.pinF.selectN) begin
			next_q.ctrl.masterMode = 1'b0;
			next_q.running = 1'b0;
			next_q.edgeCnt = '0;
			setDone = 1'b1;
		end

		// Flags: a set in the clearing cycle wins
		if (setDone) begin
			next_q.transferDoneFlag = 1'b1;
		end else if (clearDone) begin
			next_q.transferDoneFlag = 1'b0;
		end
		if (setCol) begin
			next_q.writeCollisionFlag = 1'b1;
		end else if (clearCol) begin
			next_q.writeCollisionFlag = 1'b0;
		end

		next_q.dataOut = outBit(next_q.txShift, q.ctrl.lsbFirst);
		next_q.irqLine = next_q.transferDoneFlag && q.ctrl.transferIrqEnable
			&& globalIrqEnable;

		// Pin enables held in flops so the drivers never see a gate glitch
		next_q.masterDrive = next_q.ctrl.portEnable && next_q.ctrl.masterMode;
		next_q.slaveDrive = next_q.ctrl.portEnable && !next_q.ctrl.masterMode
			&& !next_q.pinF.selectN;
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// Outputs straight from state
	assign prdata = q.rdata;
	assign pready = q.ready;
	assign pslverr = q.slvErr;
	assign irq = q.irqLine;
	assign sckOut = q.sckLevel;
	assign sckOe = q.masterDrive;
	assign mosiOut = q.dataOut;
	assign mosiOe = q.masterDrive;
	assign misoOut = q.dataOut;
	assign misoOe = q.slaveDrive;
endmodule
`default_nettype wire

// >>> test/ssdm_serial_port_asserts.sv
// Checker of bus timing, interrupt and pin enables of the serial port
`default_nettype none
module ssdm_serial_port_asserts (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Interrupt and pins
	input wire logic        globalIrqEnable,
	input wire logic        vectorTaken,
	input wire logic        irq,
	input wire logic        selectInN,
	input wire logic        sckOe,
	input wire logic        mosiOe,
	input wire logic        misoOe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Ready, interrupt and clock and slave data enables quiet in the first cycle after reset release
	a_reset_quiet: assert property ($fell(reset) |-> !pready && !irq && !sckOe && !misoOe)
		else $error("outputs not quiet after reset");
	// Bus answer and address decode
	a_ready_one_pulse: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not one pulse after setup");
	a_unmapped_err: assert property (psel && !penable && paddr > 8'h08
		|=> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && !penable && paddr[1:0] == 2'h0 && paddr <= 8'h08
		|=> !pslverr)
		else $error("mapped access refused");
	a_status_reserved: assert property (pready && !pwrite && paddr == ssdm_pkg::ADDR_STATUS
		|-> prdata[5:1] == 5'h00 && prdata[31:8] == 24'h0)
		else $error("reserved status bits not zero");
	// Interrupt gating and clearing
	a_irq_gated: assert property (!globalIrqEnable |=> !irq)
		else $error("irq while globally disabled");
	a_vector_clears: assert property (vectorTaken |-> ##2 !irq)
		else $error("irq kept after vector entry");
	// Pin drivers
	a_master_pins: assert property (sckOe == mosiOe)
		else $error("clock and data enables differ");
	a_miso_excl: assert property (misoOe |-> !mosiOe)
		else $error("slave and master drivers both on");
	a_select_abort: assert property ($fell(selectInN) && mosiOe |-> ##[1:8] !mosiOe)
		else $error("master kept after select low");
	// Main scenarios
	c_refused: cover property (pslverr);
	c_irq: cover property (irq);
	c_abort: cover property ($fell(mosiOe));
	c_slave: cover property (misoOe);
endmodule
bind ssdm_serial_port ssdm_serial_port_asserts ssdm_serial_port_asserts_i (.clk, .reset, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .globalIrqEnable, .vectorTaken,
	.irq, .selectInN, .sckOe, .mosiOe, .misoOe);
`default_nettype wire

// >>> test/ssdm_slave_model.sv
// Behavioural external serial slave facing the port in master mode
`default_nettype none
module ssdm_slave_model (
	// Clock and serial lines
	input wire logic        clk,
	input wire logic        sck,
	input wire logic        mosi,
	output var logic        miso,
	// Bench control
	input wire logic        sel,
	input wire logic        load,
	input wire logic        clock_polarity_bit,
	input wire logic        clock_phase_bit,
	input wire logic [7:0]  txByte,
	output var logic [7:0]  rxByte,
	output var int          halfCyc
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] sh = 9'h000;
	logic       lastSck = 1'b0;
	logic       held = 1'b0;
	int         cnt = 0;
	// Released line shows the inverse of its last level
	assign miso = sel ? sh[8] : ~held;
	// Leading edge leaves idle level; phase picks sample or setup
	always @(posedge clk) begin
		cnt <= cnt + 1;
		lastSck <= sck;
		if (sel)
			held <= sh[8];
		if (load)
			sh <= clock_phase_bit ? {1'b0, txByte} : {txByte, 1'b0};
		else if (sck != lastSck) begin
			halfCyc <= cnt;
			cnt <= 1;
			if ((sck != clock_polarity_bit) ^ clock_phase_bit)
				rxByte <= {rxByte[6:0], mosi};
			else
				sh <= {sh[7:0], 1'b0};
		end
	end
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench of the serial port against an external slave model
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, reset, psel, penable, pwrite, globalIrqEnable, vectorTaken, irq, err;
	logic        selectInN, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, pready, pslverr;
	logic        slvMiso, slvSel, slvLoad, clock_polarity_bit, clock_phase_bit, col, vec, extSck, extMosi;
	logic [7:0]  paddr, txByte, rxByte, wr, got;
	logic [31:0] pwdata, prdata, rd;
	int          halfCyc, hExp, miscompares, num_checks, cycles;
	int          divs [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
	// Shared lines seen by both parties
	wire         sckLine = sckOe ? sckOut : extSck;
	wire         mosiLine = mosiOe ? mosiOut : extMosi;
	wire         misoLine = misoOe ? misoOut : slvMiso;
	ssdm_serial_port ssdm_serial_port_i (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .globalIrqEnable, .vectorTaken, .irq, .selectInN,
		.sckIn(sckLine), .mosiIn(mosiLine), .misoIn(misoLine), .sckOut, .sckOe, .mosiOut,
		.mosiOe, .misoOut, .misoOe);
	ssdm_slave_model ssdm_slave_model_i (.clk, .sck(sckLine), .mosi(mosiLine), .miso(slvMiso),
		.sel(slvSel), .load(slvLoad), .clock_polarity_bit, .clock_phase_bit, .txByte, .rxByte, .halfCyc);
	// Clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("MISMATCH %s exp %h got %h", n, e, g);
			miscompares++;
		end
	endtask
	// One bus transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic tally_and_finish();
		if (miscompares == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Main sequence: every mode, rate and double bit
	initial begin
		{psel, penable, pwrite, vectorTaken, slvSel, slvLoad, clock_polarity_bit, clock_phase_bit} = 8'h00;
		{paddr, txByte, pwdata} = 48'h0;
		{extSck, extMosi} = 2'h1;
		{globalIrqEnable, selectInN, reset} = 3'h7;
		{miscompares, num_checks, cycles} = '0;
		rd = $urandom(3);
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		apb(0, 8'h04, 0);
		chk("status_reset", 32'h0, rd);
		apb(0, 8'h0C, 0);
		chk("unmapped_err", 32'h1, {31'h0, err});
		for (int i = 0; i < 32; i++) begin
			{clock_polarity_bit, clock_phase_bit} <= i[4:3];
			col = i[3] ^ i[0];
			vec = i[1] ^ i[4];
			hExp = divs[i[0] * 4 + i[2:1]] / 2;
			globalIrqEnable <= 1'($urandom);
			txByte <= 8'($urandom);
			wr = 8'($urandom);
			apb(1, 8'h00, {23'h0, 5'h1D, i[4:3], i[2:1]});
			apb(1, 8'h04, {31'h0, i[0]});
			chk("sck_idle", {31'h0, i[4]}, {31'h0, sckOut});
			slvSel <= 1'b1;
			slvLoad <= 1'b1;
			@(posedge clk);
			slvLoad <= 1'b0;
			apb(1, 8'h08, {24'h0, wr});
			if (col)
				apb(1, 8'h08, {24'h0, ~wr});
			rd = 32'h0;
			while (!rd[7])
				apb(0, 8'h04, 0);
			chk("status_done", {24'h0, 1'b1, col, 5'h0, i[0]}, rd);
			chk("irq", {31'h0, globalIrqEnable}, {31'h0, irq});
			chk("sent_byte", {24'h0, wr}, {24'h0, rxByte});
			chk("half_period", hExp, halfCyc);
			if (vec) begin
				vectorTaken <= 1'b1;
				@(posedge clk);
				vectorTaken <= 1'b0;
				apb(0, 8'h04, 0);
				chk("status_vector", {24'h0, 1'b0, col, 5'h0, i[0]}, rd);
			end
			apb(0, 8'h08, 0);
			if (hExp >= 8)
				chk("recv_byte", {24'h0, txByte}, rd);
			apb(0, 8'h04, 0);
			chk("status_clear", {31'h0, i[0]}, rd);
			slvSel <= 1'b0;
		end
		// Select pulled low while master
		apb(1, 8'h00, 32'h150);
		selectInN <= 1'b0;
		repeat (8) @(posedge clk);
		apb(0, 8'h04, 0);
		chk("status_select", 32'h81, rd);
		apb(0, 8'h00, 0);
		chk("master_dropped", 32'h0, {31'h0, rd[4]});
		selectInN <= 1'b1;
		// Slave role: bench acts as far master, link period eight system clocks
		for (int m = 0; m < 4; m++) begin
			txByte <= 8'($urandom);
			wr = 8'($urandom);
			extSck <= m[1];
			apb(1, 8'h00, {23'h0, 5'h04, 2'(m), 2'h0});
			apb(1, 8'h08, {24'h0, wr});
			selectInN <= 1'b0;
			extMosi <= txByte[7];
			repeat (8) @(posedge clk);
			for (int b = 7; b >= 0; b--) begin
				extSck <= !m[1]; // Leading edge, four clocks per half period
				if (m[0])
					extMosi <= txByte[b];
				repeat (4) @(posedge clk);
				extSck <= m[1];
				if (!m[0] && b > 0)
					extMosi <= txByte[b - 1];
				// Slave data lags the pin filter, so it is read mid-half
				repeat (2) @(posedge clk);
				got[b] = misoLine;
				repeat (2) @(posedge clk);
			end
			selectInN <= 1'b1;
			apb(0, 8'h04, 0);
			chk("slave_done", 32'h81, rd);
			apb(0, 8'h08, 0);
			chk("slave_recv", {24'h0, txByte}, rd);
			chk("slave_sent", {24'h0, wr}, {24'h0, got});
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
